// ### common/oomc_pkg.sv
// Constants and carrier types for the on/off and margin control block
package oomc_pkg;

    localparam int BYTE_W = 8;

    // Run/margin byte field positions
    localparam int OP_ACT_HI = 7;
    localparam int OP_ACT_LO = 6;
    localparam int OP_MRG_HI = 5;
    localparam int OP_MRG_LO = 4;
    localparam int OP_FLT_HI = 3;
    localparam int OP_FLT_LO = 2;

    // Run/margin field codes
    localparam logic [1:0] ACT_FAST = 2'h0;
    localparam logic [1:0] ACT_SOFT = 2'h1;
    localparam logic [1:0] ACT_ON = 2'h2;
    localparam logic [1:0] MRG_OFF = 2'h0;
    localparam logic [1:0] MRG_LOW = 2'h1;
    localparam logic [1:0] MRG_HIGH = 2'h2;
    localparam logic [1:0] FLT_IGN = 2'h1;
    localparam logic [1:0] FLT_ACT = 2'h2;

    // Enable-source byte field positions
    localparam int CFG_RSV_HI = 7;
    localparam int CFG_RSV_LO = 5;
    localparam int CFG_GATED = 4;
    localparam int CFG_BUS = 3;
    localparam int CFG_PIN = 2;
    localparam int CFG_POL = 1;
    localparam int CFG_FAST = 0;
    localparam logic [2:0] CFG_RSV_VAL = 3'h0;

    // Reset values of the two command bytes
    localparam logic [BYTE_W-1:0] RUN_RST = 8'h00;
    localparam logic [BYTE_W-1:0] CFG_RST = 8'h00;

    // Which command byte a write targets
    typedef enum logic {
        SEL_RUN = 1'b0,
        SEL_CFG = 1'b1
    } oomc_sel_t;

    // One command byte write from the bus transport
    typedef struct packed {
        logic wr;
        oomc_sel_t sel;
        logic [BYTE_W-1:0] data;
    } oomc_cmd_t;

    // Margin state handed to the voltage setpoint logic
    typedef struct packed {
        logic [1:0] level;
        logic act;
    } oomc_margin_t;

    // Output voltage warnings and faults
    typedef struct packed {
        logic ov_warn;
        logic ov_fault;
        logic uv_warn;
        logic uv_fault;
    } oomc_flt_t;

    // Output enable state
    typedef enum logic {
        ST_OFF = 1'b0,
        ST_ON = 1'b1
    } oomc_state_t;

endpackage : oomc_pkg

// ### core/oomc_core.sv
// On/off, enable source and margin control decoder
`timescale 1ns/1ps
module oomc_core
    import oomc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Command byte writes
    input wire oomc_cmd_t cmd,
    // Remote enable pin, asynchronous
    input wire logic ctl_pin,
    // Voltage monitor conditions
    input wire oomc_flt_t flt_in,
    // Command byte read-back and rejected-byte fault pulse
    output logic [BYTE_W-1:0] run_margin_q,
    output logic [BYTE_W-1:0] enable_source_q,
    output logic comm_fault,
    // Sequencer and fault response side
    output logic out_en_req,
    output logic fast_off,
    output oomc_margin_t margin,
    output oomc_flt_t flt_out
);

    // Run/margin byte matches a defined encoding
    function automatic logic run_ok(input logic [BYTE_W-1:0] b);
        logic [1:0] act;
        logic [1:0] mrg;
        logic [1:0] flt;
        act = b[OP_ACT_HI:OP_ACT_LO];
        mrg = b[OP_MRG_HI:OP_MRG_LO];
        flt = b[OP_FLT_HI:OP_FLT_LO];
        run_ok = 1'b0;
        if (act == ACT_FAST || act == ACT_SOFT) begin
            run_ok = 1'b1;
        end else if (act == ACT_ON) begin
            if (mrg == MRG_OFF) begin
                run_ok = 1'b1;
            end else if (mrg == MRG_LOW || mrg == MRG_HIGH) begin
                run_ok = (flt == FLT_IGN) || (flt == FLT_ACT);
            end
        end
    endfunction : run_ok

    // Enable-source byte matches a defined encoding
    function automatic logic cfg_ok(input logic [BYTE_W-1:0] b);
        cfg_ok = (b[CFG_RSV_HI:CFG_RSV_LO] == CFG_RSV_VAL);
    endfunction : cfg_ok

    logic [BYTE_W-1:0] run_ff;
    logic [BYTE_W-1:0] cfg_ff;
    logic fault_ff;
    logic ctl_s1_ff;
    logic ctl_s2_ff;
    oomc_state_t state_ff;
    oomc_state_t nxt_state;
    logic fast_ff;
    logic nxt_fast;
    oomc_margin_t margin_ff;
    oomc_margin_t nxt_margin;
    oomc_flt_t flt_ff;
    logic wr_ok;
    logic [1:0] act;
    logic pin_on;
    logic bus_req;
    logic pin_req;
    logic run_req;
    logic bus_off;
    logic pin_off;

    // Validity of the byte offered this cycle
    assign wr_ok = (cmd.sel == SEL_RUN) ? run_ok(cmd.data)
                                        : cfg_ok(cmd.data);

    // Command byte storage; invalid bytes leave the old value
    // A refused byte must not disturb the running state
    always_ff @(posedge clk) begin
        if (!nrst) begin
            run_ff <= RUN_RST;
            cfg_ff <= CFG_RST;
        end else if (cmd.wr && wr_ok) begin
            if (cmd.sel == SEL_RUN) begin
                run_ff <= cmd.data;
            end else begin
                cfg_ff <= cmd.data;
            end
        end
    end

    // Communication fault pulse for a rejected byte
    always_ff @(posedge clk) begin
        if (!nrst) begin
            fault_ff <= 1'b0;
        end else begin
            fault_ff <= cmd.wr && !wr_ok;
        end
    end

    // Two-stage synchroniser for the enable pin
    // Only the second stage feeds logic; the first may be metastable
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctl_s1_ff <= 1'b0;
            ctl_s2_ff <= 1'b0;
        end else begin
            ctl_s1_ff <= ctl_pin;
            ctl_s2_ff <= ctl_s1_ff;
        end
    end

    // Enable source combination
    always_comb begin
        act = run_ff[OP_ACT_HI:OP_ACT_LO];
        pin_on = (ctl_s2_ff == cfg_ff[CFG_POL]);
        bus_req = !cfg_ff[CFG_BUS] || (act == ACT_ON);
        pin_req = !cfg_ff[CFG_PIN] || pin_on;
        if (!cfg_ff[CFG_GATED]) begin
            run_req = 1'b1;
        end else begin
            run_req = (cfg_ff[CFG_BUS] || cfg_ff[CFG_PIN])
                      && bus_req && pin_req;
        end
        bus_off = cfg_ff[CFG_GATED] && !bus_req;
        pin_off = cfg_ff[CFG_GATED] && !pin_req;
    end

    // Next output state and shutdown style
    always_comb begin
        nxt_state = state_ff;
        nxt_fast = fast_ff;
        unique case (state_ff)
            ST_OFF: begin
                if (run_req) begin
                    nxt_state = ST_ON;
                    nxt_fast = 1'b0;
                end
            end
            ST_ON: begin
                if (!run_req) begin
                    nxt_state = ST_OFF;
                    nxt_fast = (bus_off && act == ACT_FAST)
                               || (pin_off && cfg_ff[CFG_FAST]);
                end
            end
        endcase
    end

    // Output state register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_ff <= ST_OFF;
            fast_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            fast_ff <= nxt_fast;
        end
    end

    // Margin selection, only while running by bus command
    // Next state is used so margin and enable move together
    always_comb begin
        nxt_margin.level = MRG_OFF;
        nxt_margin.act = 1'b1;
        if (nxt_state == ST_ON && act == ACT_ON) begin
            nxt_margin.level = run_ff[OP_MRG_HI:OP_MRG_LO];
            nxt_margin.act = (run_ff[OP_FLT_HI:OP_FLT_LO] == FLT_ACT);
        end
    end

    // Margin state register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            margin_ff <= '{level: MRG_OFF, act: 1'b1};
        end else begin
            margin_ff <= nxt_margin;
        end
    end

    // Fault gating by margin mode
    // Gating follows the registered margin, one cycle behind a change
    always_ff @(posedge clk) begin
        if (!nrst) begin
            flt_ff <= '0;
        end else begin
            flt_ff <= flt_in;
            if (margin_ff.level == MRG_HIGH && !margin_ff.act) begin
                flt_ff.ov_warn <= 1'b0;
                flt_ff.ov_fault <= 1'b0;
            end
            if (margin_ff.level == MRG_LOW && !margin_ff.act) begin
                flt_ff.uv_warn <= 1'b0;
                flt_ff.uv_fault <= 1'b0;
            end
        end
    end

    // Outputs
    assign run_margin_q = run_ff;
    assign enable_source_q = cfg_ff;
    assign comm_fault = fault_ff;
    assign out_en_req = (state_ff == ST_ON);
    assign fast_off = fast_ff;
    assign margin = margin_ff;
    assign flt_out = flt_ff;

    // Checks
    // Reset is synchronous: the release edge still samples reset values
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_bad_run_flag: assert property (
        cmd.wr && cmd.sel == SEL_RUN && !run_ok(cmd.data)
        |=> comm_fault && $stable(run_margin_q))
        else $error("bad run byte not rejected");

    a_bad_cfg_flag: assert property (
        cmd.wr && cmd.sel == SEL_CFG
        && cmd.data[CFG_RSV_HI:CFG_RSV_LO] != CFG_RSV_VAL
        |=> comm_fault && $stable(enable_source_q))
        else $error("bad config byte not rejected");

    a_low_bits_free: assert property (
        cmd.wr && cmd.sel == SEL_RUN && run_ok(cmd.data)
        |=> run_margin_q == $past(cmd.data) && !comm_fault)
        else $error("valid run byte not stored");

    a_imm_off: assert property (
        state_ff == ST_ON && cfg_ff[CFG_GATED] && cfg_ff[CFG_BUS]
        && act == ACT_FAST |=> !out_en_req && fast_off)
        else $error("immediate off not fast");

    a_soft_off: assert property (
        state_ff == ST_ON && cfg_ff[CFG_GATED] && cfg_ff[CFG_BUS]
        && act == ACT_SOFT && pin_req |=> !out_en_req && !fast_off)
        else $error("soft off not sequenced");

    // Skip the attempt taken at the release edge
    a_ungated_on: assert property (
        nrst && !cfg_ff[CFG_GATED] |=> out_en_req)
        else $error("ungated unit not running");

    a_both_needed: assert property (
        cfg_ff[CFG_GATED] && cfg_ff[CFG_BUS] && cfg_ff[CFG_PIN]
        |=> out_en_req == ($past(act) == ACT_ON && $past(pin_on)))
        else $error("bus and pin not combined");

    a_pin_polarity: assert property (
        cfg_ff[CFG_GATED] && !cfg_ff[CFG_BUS] && cfg_ff[CFG_PIN]
        |=> out_en_req
            == ($past(ctl_s2_ff) == $past(cfg_ff[CFG_POL])))
        else $error("pin polarity wrong");

    a_pin_style: assert property (
        state_ff == ST_ON && pin_off && !bus_off
        |=> !out_en_req && fast_off == $past(cfg_ff[CFG_FAST]))
        else $error("pin turn-off style wrong");

    a_hold_state: assert property (
        state_ff == ST_ON && run_req |=> out_en_req)
        else $error("output dropped without cause");

    a_ign_ov: assert property (
        margin_ff.level == MRG_HIGH && !margin_ff.act
        |=> !flt_out.ov_warn && !flt_out.ov_fault)
        else $error("overvoltage not suppressed");

    a_act_uv: assert property (
        margin_ff.level == MRG_LOW && margin_ff.act
        |=> flt_out.uv_fault == $past(flt_in.uv_fault))
        else $error("undervoltage fault lost");

    // Mirror of the high-ignore check for the undervoltage pair
    a_ign_uv: assert property (
        margin_ff.level == MRG_LOW && !margin_ff.act
        |=> !flt_out.uv_warn && !flt_out.uv_fault)
        else $error("undervoltage not suppressed");

    // Fast-off is a turn-off qualifier and must be clear when running
    a_fast_clear: assert property (
        $rose(out_en_req) |-> !fast_off)
        else $error("fast-off left set at turn-on");

    // Bus alone decides when the pin is not a source
    a_bus_only: assert property (
        cfg_ff[CFG_GATED] && cfg_ff[CFG_BUS] && !cfg_ff[CFG_PIN]
        |=> out_en_req == ($past(act) == ACT_ON))
        else $error("bus-only control wrong");

    // A bus off byte must not stop a pin-only unit
    a_bus_ignored: assert property (
        cfg_ff[CFG_GATED] && !cfg_ff[CFG_BUS] && cfg_ff[CFG_PIN]
        && pin_on && act != ACT_ON |=> out_en_req)
        else $error("bus on/off not ignored");

    // Gated with no source selected can never start
    a_no_source: assert property (
        cfg_ff[CFG_GATED] && !cfg_ff[CFG_BUS] && !cfg_ff[CFG_PIN]
        |=> !out_en_req)
        else $error("unit ran with no enable source");

    // A margin level is only reported while the output runs
    a_margin_run: assert property (
        margin.level != MRG_OFF |-> out_en_req)
        else $error("margin set while output off");

    // Good config bytes land unchanged and raise no fault
    a_good_cfg: assert property (
        cmd.wr && cmd.sel == SEL_CFG
        && cmd.data[CFG_RSV_HI:CFG_RSV_LO] == CFG_RSV_VAL
        |=> enable_source_q == $past(cmd.data) && !comm_fault)
        else $error("valid config byte not stored");

    // A fault pulse always follows a write strobe
    a_fault_cause: assert property (
        comm_fault |-> $past(cmd.wr))
        else $error("comm fault without a write");

    // Main scenarios
    c_imm_off: cover property (
        out_en_req ##1 !out_en_req && fast_off);
    c_soft_off: cover property (
        out_en_req ##1 !out_en_req && !fast_off);
    c_margin_ign: cover property (
        margin_ff.level == MRG_HIGH && !margin_ff.act && flt_in.ov_warn);
    c_comm_fault: cover property (comm_fault);
    c_both_on: cover property (
        cfg_ff[CFG_GATED] && cfg_ff[CFG_BUS] && cfg_ff[CFG_PIN]
        && out_en_req);

endmodule : oomc_core

// ### verification/oomc_host.sv
// Host-side model that issues command byte writes
`timescale 1ns/1ps
module oomc_host
    import oomc_pkg::*;
(
    // Clock
    input wire logic clk,
    // Command byte writes toward the block
    output oomc_cmd_t cmd
);
    // Idle bus before the first write
    initial begin
        cmd = '{wr: 1'b0, sel: SEL_RUN, data: 8'h00};
    end

    // One byte write; data goes stale once the strobe drops
    task automatic put(input oomc_sel_t s, input logic [7:0] d);
        @(posedge clk);
        cmd <= '{wr: 1'b1, sel: s, data: d};
        @(posedge clk);
        cmd.wr <= 1'b0;
        cmd.data <= ~d;
    endtask : put
endmodule : oomc_host

// ### verification/tb.sv
// Testbench for the on/off and margin control block
`timescale 1ns/1ps
module tb;
    import oomc_pkg::*;
    logic clk;
    logic nrst;
    logic ctl_pin;
    oomc_cmd_t cmd;
    oomc_flt_t flt_in;
    oomc_flt_t flt_out;
    oomc_margin_t margin;
    logic [7:0] run_q;
    logic [7:0] cfg_q;
    logic comm_fault;
    logic out_en_req;
    logic fast_off;
    int bad_count;
    int total_checks;
    int cyc;

    // Host model and block under test
    oomc_host u_host (.clk(clk), .cmd(cmd));
    oomc_core u_dut (
        .clk(clk), .nrst(nrst), .cmd(cmd), .ctl_pin(ctl_pin),
        .flt_in(flt_in), .run_margin_q(run_q), .enable_source_q(cfg_q),
        .comm_fault(comm_fault), .out_en_req(out_en_req),
        .fast_off(fast_off), .margin(margin), .flt_out(flt_out)
    );

    // Clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic end_sim();
        if (bad_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    // Cut a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : chk

    // Write one byte, check the fault pulse, let outputs settle
    task automatic wr(input oomc_sel_t s, input logic [7:0] d,
        input logic f);
        u_host.put(s, d);
        #1;
        chk({7'h00, comm_fault}, {7'h00, f});
        repeat (4) @(posedge clk);
        #1;
    endtask : wr

    // Move the enable pin, spaced like the slow link
    task automatic pin(input logic v);
        @(posedge clk);
        ctl_pin <= v;
        repeat (25) @(posedge clk);
        #1;
    endtask : pin

    // Enable request and fast-off qualifier together
    task automatic st(input logic [1:0] e);
        chk({6'h00, out_en_req, fast_off}, {6'h00, e});
    endtask : st

    // Main sequence
    initial begin
        bad_count = 0;
        total_checks = 0;
        cyc = 0;
        nrst = 1'b0;
        ctl_pin = 1'b1;
        flt_in = 4'h0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(run_q, 8'h00);
        chk(cfg_q, 8'h00);
        st(2'h2);
        chk({5'h00, margin}, 8'h01);
        wr(SEL_RUN, 8'h00, 1'b0);
        st(2'h2);
        wr(SEL_RUN, 8'h80, 1'b0);
        wr(SEL_CFG, 8'h18, 1'b0);
        st(2'h2);
        wr(SEL_RUN, 8'h00, 1'b0);
        st(2'h1);
        wr(SEL_RUN, 8'h80, 1'b0);
        st(2'h2);
        wr(SEL_RUN, 8'h40, 1'b0);
        st(2'h0);
        // Margin low ignoring faults, low bits set
        wr(SEL_RUN, 8'h97, 1'b0);
        chk(run_q, 8'h97);
        chk({5'h00, margin}, 8'h02);
        @(posedge clk);
        flt_in <= 4'hF;
        repeat (2) @(posedge clk);
        #1;
        chk({4'h0, flt_out}, 8'h0C);
        wr(SEL_RUN, 8'hA8, 1'b0);
        chk({5'h00, margin}, 8'h05);
        chk({4'h0, flt_out}, 8'h0F);
        wr(SEL_RUN, 8'hA4, 1'b0);
        chk({4'h0, flt_out}, 8'h03);
        // Margin low acting on faults passes the undervoltage pair
        wr(SEL_RUN, 8'h98, 1'b0);
        chk({5'h00, margin}, 8'h03);
        chk({4'h0, flt_out}, 8'h0F);
        @(posedge clk);
        flt_in <= 4'h0;
        // Refused bytes leave stored values alone
        wr(SEL_RUN, 8'hC0, 1'b1);
        wr(SEL_RUN, 8'hB4, 1'b1);
        chk(run_q, 8'h98);
        wr(SEL_CFG, 8'h38, 1'b1);
        chk(cfg_q, 8'h18);
        repeat (50) @(posedge clk);
        #1;
        st(2'h2);
        pin(1'b0);
        pin(1'b1);
        st(2'h2);
        // Pin only, active low, sequenced off
        wr(SEL_CFG, 8'h14, 1'b0);
        chk({7'h00, out_en_req}, 8'h00);
        pin(1'b0);
        st(2'h2);
        pin(1'b1);
        st(2'h0);
        pin(1'b0);
        wr(SEL_RUN, 8'h40, 1'b0);
        st(2'h2);
        // Pin only, active high, fast off
        wr(SEL_CFG, 8'h17, 1'b0);
        chk({7'h00, out_en_req}, 8'h00);
        pin(1'b1);
        st(2'h2);
        pin(1'b0);
        st(2'h1);
        // Bus and pin both required
        wr(SEL_CFG, 8'h1C, 1'b0);
        chk({7'h00, out_en_req}, 8'h00);
        wr(SEL_RUN, 8'h80, 1'b0);
        st(2'h2);
        pin(1'b1);
        st(2'h0);
        pin(1'b0);
        st(2'h2);
        wr(SEL_RUN, 8'h00, 1'b0);
        st(2'h1);
        // Running unit stops when no source is selected
        wr(SEL_RUN, 8'h80, 1'b0);
        st(2'h2);
        wr(SEL_CFG, 8'h10, 1'b0);
        st(2'h0);
        end_sim();
    end
endmodule : tb
